// ---- psf_pkg.sv ----
// constants and types for the status word block
//
// Contract
// - negative flag takes bit 31 of the result
// - zero flag is one when the result is zero
// - flag-setting additions set carry on unsigned overflow
// - flag-setting subtractions clear carry on borrow, set it otherwise
// - non-arithmetic shifting operations load carry with the last bit shifted out
// - non-arithmetic operations without shift keep carry and overflow
// - additions and subtractions set overflow on signed overflow
// - compares always set flags; others only in flag form, not to program counter
// - flag form with program counter destination copies saved word into current
// - bit 27 is the sticky saturation flag, saved and restored with the word
// - halfword operations write upper and lower lane-compare pairs together
// - byte operations write each lane-compare bit from its own byte lane
// - lane bit set on unsigned add carry, else when result non-negative
// - bit 9 selects data byte order; instruction fetch ignores it
// - abort mask bit 8 blocks imprecise data aborts
// - normal interrupt mask blocks normal interrupt requests
// - fast interrupt mask blocks fast interrupt requests
// - mode field decodes seven modes, five with their own saved word; code banks five, none for user and system
// - two instruction-set bits select base, compact or bytecode set
// - compact bit without compact support faults the next instruction
// - bytecode branch without accelerator acts as branch exchange, bit stays clear
// - reserved bits read zero and ignore writes
// - user mode cannot write masks, mode or instruction-set bits
package psf_pkg;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int N_BIT   = 31;
    localparam int Z_BIT   = 30;
    localparam int C_BIT   = 29;
    localparam int V_BIT   = 28;
    localparam int Q_BIT   = 27;
    localparam int J_BIT   = 24;
    localparam int GE_LO   = 16;
    localparam int E_BIT   = 9;
    localparam int A_BIT   = 8;
    localparam int I_BIT   = 7;
    localparam int F_BIT   = 6;
    localparam int T_BIT   = 5;

    // ----------------------------------------------------------------
    // masks and reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] VALID_MASK = 32'hF90F03FF;
    localparam logic [31:0] USER_MASK  = 32'hF80F0200;
    localparam logic [31:0] CUR_RESET  = 32'h000001D3;
    localparam logic [31:0] SAV_RESET  = 32'h00000000;

    // ----------------------------------------------------------------
    // modes and banks
    // ----------------------------------------------------------------
    localparam logic [4:0] MODE_USR = 5'h10;
    localparam logic [4:0] MODE_FIQ = 5'h11;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_ABT = 5'h17;
    localparam logic [4:0] MODE_UND = 5'h1B;
    localparam logic [4:0] MODE_SYS = 5'h1F;
    localparam int         NUM_BANKS = 5;
    localparam logic [2:0] BANK_NONE = 3'h7;

    typedef enum logic [1:0] {PSF_OP_LOGIC, PSF_OP_SHIFT, PSF_OP_ADD, PSF_OP_SUB} psf_op_t;

    typedef struct packed {
        logic [31:0]                 cur;
        logic [NUM_BANKS-1:0][31:0] sav;
        logic [31:0]                 sav_out;
        logic                        irq_ok;
        logic                        fiq_ok;
        logic                        abt_ok;
        logic                        fault;
    } psf_state_t;

endpackage

// ---- psf_status.sv ----
// current and banked saved status words with flag, mask and mode update
module psf_status
    import psf_pkg::*;
#(
    parameter bit HAS_COMPACT  = 1'b1,
    parameter bit HAS_BYTECODE = 1'b0
)
(
    input  wire logic        clock,
    input  wire logic        reset,
    // instruction completion
    input  wire logic        op_valid,
    input  wire psf_op_t     op_class,
    input  wire logic        op_set_flags,
    input  wire logic        op_is_compare,
    input  wire logic        op_dest_pc,
    input  wire logic [31:0] op_a,
    input  wire logic [31:0] op_b,
    input  wire logic        op_carry_in,
    input  wire logic [31:0] op_result,
    input  wire logic        shifter_carry,
    input  wire logic        sat_set,
    // packed lane operations
    input  wire logic        simd_valid,
    input  wire logic        simd_half,
    input  wire logic        simd_signed,
    input  wire logic        simd_sub,
    input  wire logic [31:0] simd_a,
    input  wire logic [31:0] simd_b,
    // status word writes
    input  wire logic        wr_valid,
    input  wire logic        wr_saved,
    input  wire logic [3:0]  wr_bytes,
    input  wire logic [31:0] wr_data,
    // branches that may change instruction set
    input  wire logic        bx_valid,
    input  wire logic        bx_to_bytecode,
    input  wire logic        bx_target_lsb,
    input  wire logic        accel_enable,
    // exception entry
    input  wire logic        exc_valid,
    input  wire logic [4:0]  exc_mode,
    input  wire logic        exc_big_endian,
    // request qualification
    input  wire logic        irq_req,
    input  wire logic        fiq_req,
    input  wire logic        abort_req,
    // status outputs
    output logic [31:0]      current_status_word,
    output logic [31:0]      saved_status_word,
    output logic [4:0]       mode,
    output logic [1:0]       iset,
    output logic             data_big_endian,
    output logic             irq_accept,
    output logic             fiq_accept,
    output logic             abort_accept,
    output logic             compact_fault
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // mode to saved bank
    function automatic logic [2:0] psf_bank(input logic [4:0] m);
        logic [2:0] b;
        b = BANK_NONE;
        unique case (m)
            MODE_FIQ: b = 3'h0;
            MODE_IRQ: b = 3'h1;
            MODE_SVC: b = 3'h2;
            MODE_ABT: b = 3'h3;
            MODE_UND: b = 3'h4;
            default:  b = BANK_NONE;
        endcase
        return b;
    endfunction

    // lanes extended to 17 bits so one sign test serves bytes and halves
    function automatic logic [3:0] psf_lane_ge(
        input logic        half,
        input logic        sgn,
        input logic        sub,
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic [16:0] ea;
        logic [16:0] eb;
        logic [16:0] r;
        logic        g;
        logic [3:0]  ge;
        ge = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (half)
            begin
                ea = sgn ? {a[16*(i%2)+15], a[16*(i%2) +: 16]} : {1'b0, a[16*(i%2) +: 16]};
                eb = sgn ? {b[16*(i%2)+15], b[16*(i%2) +: 16]} : {1'b0, b[16*(i%2) +: 16]};
            end
            else
            begin
                ea = sgn ? {{9{a[8*i+7]}}, a[8*i +: 8]} : {9'h000, a[8*i +: 8]};
                eb = sgn ? {{9{b[8*i+7]}}, b[8*i +: 8]} : {9'h000, b[8*i +: 8]};
            end
            r = sub ? ea - eb : ea + eb;
            // carry for unsigned add, sign otherwise
            if (!sgn && !sub)
                g = half ? r[16] : r[8];
            else
                g = !r[16];
            // pairs for halves, single bits for bytes
            if (!half)
                ge[i] = g;
            else if (i < 2)
                ge[2*i] = g;
        end
        if (half)
            ge = {ge[2], ge[2], ge[0], ge[0]};
        return ge;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    psf_state_t  s_reg;
    psf_state_t  s_next;

    logic [31:0] b_eff;
    logic [32:0] sum;
    logic [31:0] res;
    logic        arith;
    logic        fl_go;
    logic        ret_go;
    logic        priv;
    logic        accel_on;
    logic [2:0]  cur_bank;
    logic [2:0]  exc_bank;
    logic [31:0] wmask;
    logic [31:0] bmask;
    logic [3:0]  ge_new;

    assign arith    = (op_class == PSF_OP_ADD) || (op_class == PSF_OP_SUB);
    // subtract as add of inverse, carry out means no borrow
    assign b_eff    = (op_class == PSF_OP_SUB) ? ~op_b : op_b;
    assign sum      = {1'b0, op_a} + {1'b0, b_eff} + {32'h00000000, op_carry_in};
    assign res      = arith ? sum[31:0] : op_result;
    // compares always, others only in flag form away from pc
    assign fl_go    = op_valid && (op_is_compare || (op_set_flags && !op_dest_pc));
    assign ret_go   = op_valid && op_set_flags && op_dest_pc && !op_is_compare
                      && (cur_bank != BANK_NONE);
    assign priv     = s_reg.cur[4:0] != MODE_USR;
    assign accel_on = HAS_BYTECODE && accel_enable;
    assign cur_bank = psf_bank(s_reg.cur[4:0]);
    assign exc_bank = psf_bank(exc_mode);
    assign bmask    = {{8{wr_bytes[3]}}, {8{wr_bytes[2]}}, {8{wr_bytes[1]}}, {8{wr_bytes[0]}}};
    assign ge_new   = psf_lane_ge(simd_half, simd_signed, simd_sub, simd_a, simd_b);

    // reserved bits never written, user keeps privileged bits
    always_comb
    begin
        wmask = bmask & VALID_MASK;
        if (!wr_saved && !priv)
            wmask = wmask & USER_MASK;
        // current-word writes leave the bytecode bit unchanged while the accelerator is unusable
        if (!wr_saved && !accel_on)
            wmask[J_BIT] = 1'b0;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // priority: exception entry, return, then the completing instruction
    always_comb
    begin
        s_next = s_reg;
        if (exc_valid)
        begin
            if (exc_bank != BANK_NONE)
                s_next.sav[exc_bank] = s_reg.cur;
            s_next.cur[4:0]  = exc_mode;
            // entry returns to base set; saved copy keeps compact bit
            s_next.cur[T_BIT] = 1'b0;
            s_next.cur[J_BIT] = 1'b0;
            s_next.cur[I_BIT] = 1'b1;
            if (exc_mode == MODE_FIQ)
                s_next.cur[F_BIT] = 1'b1;
            if (exc_mode != MODE_UND && exc_mode != MODE_SVC)
                s_next.cur[A_BIT] = 1'b1;
            s_next.cur[E_BIT] = exc_big_endian;
        end
        else if (ret_go)
        begin
            // return copies the saved word, saturation flag included
            s_next.cur = s_reg.sav[cur_bank] & VALID_MASK;
        end
        else
        begin
            // every field lands on the same edge
            if (fl_go)
            begin
                s_next.cur[N_BIT] = res[31];
                s_next.cur[Z_BIT] = (res == 32'h00000000);
                unique case (op_class)
                    PSF_OP_ADD,
                    PSF_OP_SUB:
                    begin
                        s_next.cur[C_BIT] = sum[32];
                        s_next.cur[V_BIT] = (op_a[31] == b_eff[31]) && (sum[31] != op_a[31]);
                    end
                    PSF_OP_SHIFT:
                    begin
                        // last bit out of the shifter
                        s_next.cur[C_BIT] = shifter_carry;
                    end
                    PSF_OP_LOGIC:
                    begin
                        s_next.cur[C_BIT] = s_reg.cur[C_BIT];
                    end
                endcase
            end
            if (op_valid && sat_set)
                s_next.cur[Q_BIT] = 1'b1;
            if (simd_valid)
                s_next.cur[GE_LO +: 4] = ge_new;
            if (wr_valid && !wr_saved)
                s_next.cur = (s_next.cur & ~wmask) | (wr_data & wmask);
            if (wr_valid && wr_saved && cur_bank != BANK_NONE)
                s_next.sav[cur_bank] = (s_reg.sav[cur_bank] & ~wmask) | (wr_data & wmask);
            if (bx_valid)
            begin
                if (bx_to_bytecode && accel_on)
                begin
                    s_next.cur[J_BIT] = 1'b1;
                    s_next.cur[T_BIT] = 1'b0;
                end
                else
                begin
                    s_next.cur[J_BIT] = 1'b0;
                    s_next.cur[T_BIT] = bx_target_lsb;
                end
            end
        end
        s_next.sav_out = (psf_bank(s_next.cur[4:0]) == BANK_NONE) ? 32'h00000000
                         : s_next.sav[psf_bank(s_next.cur[4:0])];
        s_next.irq_ok = irq_req && !s_reg.cur[I_BIT];
        s_next.fiq_ok = fiq_req && !s_reg.cur[F_BIT];
        s_next.abt_ok = abort_req && !s_reg.cur[A_BIT];
        // compact state with no compact decoder
        s_next.fault  = !HAS_COMPACT && s_next.cur[T_BIT];
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s_reg.cur     <= CUR_RESET;
            s_reg.sav     <= {NUM_BANKS{SAV_RESET}};
            s_reg.sav_out <= SAV_RESET;
            s_reg.irq_ok  <= 1'b0;
            s_reg.fiq_ok  <= 1'b0;
            s_reg.abt_ok  <= 1'b0;
            s_reg.fault   <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // data order only; fetch logic must not use it
    assign data_big_endian     = s_reg.cur[E_BIT];
    assign current_status_word = s_reg.cur;
    assign saved_status_word   = s_reg.sav_out;
    assign mode                = s_reg.cur[4:0];
    assign iset                = {s_reg.cur[J_BIT], s_reg.cur[T_BIT]};
    assign irq_accept          = s_reg.irq_ok;
    assign fiq_accept          = s_reg.fiq_ok;
    assign abort_accept        = s_reg.abt_ok;
    assign compact_fault       = s_reg.fault;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    neg_flag_a: assert property (fl_go && !exc_valid && !wr_valid
        |=> current_status_word[N_BIT] == $past(res[31]))
        else $error("negative flag mismatch");

    zero_flag_a: assert property (fl_go && !exc_valid && !wr_valid
        |=> current_status_word[Z_BIT] == ($past(res) == 32'h00000000))
        else $error("zero flag mismatch");

    add_carry_a: assert property (fl_go && !exc_valid && !wr_valid
        && op_class == PSF_OP_ADD
        |=> current_status_word[C_BIT]
            == (({1'b0, $past(op_a)} + {1'b0, $past(op_b)}
                + {32'h00000000, $past(op_carry_in)}) > 33'h0FFFFFFFF))
        else $error("add carry mismatch");

    sub_carry_a: assert property (fl_go && !exc_valid && !wr_valid
        && op_class == PSF_OP_SUB && op_carry_in
        |=> current_status_word[C_BIT] == ($past(op_a) >= $past(op_b)))
        else $error("subtract carry mismatch");

    // logic form keeps carry and overflow
    keep_cv_a: assert property (fl_go && !exc_valid && !wr_valid
        && op_class == PSF_OP_LOGIC
        |=> $stable(current_status_word[C_BIT:V_BIT]))
        else $error("carry or overflow changed");

    ret_copy_a: assert property (ret_go && !exc_valid
        |=> current_status_word == ($past(saved_status_word) & VALID_MASK))
        else $error("return did not restore saved word");

    ge_pair_a: assert property (simd_valid && simd_half && !exc_valid && !ret_go && !wr_valid
        |=> current_status_word[19] == current_status_word[18]
            && current_status_word[17] == current_status_word[16])
        else $error("lane pair split");

    reserved_zero_a: assert property ((current_status_word & ~VALID_MASK) == 32'h00000000
        && (saved_status_word & ~VALID_MASK) == 32'h00000000)
        else $error("reserved bit set");

    // user mode cannot leave user mode by a write
    user_mode_a: assert property (mode == MODE_USR && wr_valid && !wr_saved
        && !exc_valid && !ret_go
        |=> mode == MODE_USR && $stable(current_status_word[A_BIT:F_BIT]))
        else $error("user write changed privileged bits");

    irq_mask_a: assert property ($past(current_status_word[I_BIT]) |-> !irq_accept)
        else $error("masked interrupt accepted");

    bytecode_clear_a: assert property (!HAS_BYTECODE |-> !iset[1])
        else $error("bytecode bit set without accelerator");

endmodule // psf_status

// ---- psf_exc_model.sv ----
// exception sequencer and request sources facing the status word block
module psf_exc_model
    import psf_pkg::*;
(
    input  wire logic       clock,
    output logic            exc_valid,
    output logic [4:0]      exc_mode,
    output logic            exc_big_endian,
    output logic            irq_req,
    output logic            fiq_req,
    output logic            abort_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // requests stay raised so that only the masks decide acceptance
    initial
    begin
        exc_valid      = 1'b0;
        exc_mode       = MODE_SVC;
        exc_big_endian = 1'b0;
        irq_req        = 1'b1;
        fiq_req        = 1'b1;
        abort_req      = 1'b1;
    end

    task automatic enter(input logic [4:0] m, input logic be);
        if (m inside {MODE_USR, MODE_FIQ, MODE_IRQ, MODE_SVC, MODE_ABT, MODE_UND, MODE_SYS})
        begin
            @(posedge clock);
            exc_mode       <= m;
            exc_big_endian <= be;
            exc_valid      <= 1'b1;
            @(posedge clock);
            exc_valid      <= 1'b0;
            #1;
        end
    endtask
endmodule // psf_exc_model

// ---- program_status_flags_tb.sv ----
// self-checking bench for the status word block
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module program_status_flags_tb
    import psf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, reset, op_valid, op_set_flags, op_is_compare, op_dest_pc, op_carry_in;
    logic shifter_carry, sat_set, simd_valid, simd_half, simd_signed, simd_sub;
    logic wr_valid, wr_saved, bx_valid, bx_to_bytecode, bx_target_lsb, accel_enable;
    logic exc_valid, exc_big_endian, irq_req, fiq_req, abort_req;
    logic data_big_endian, irq_accept, fiq_accept, abort_accept, compact_fault;
    logic [31:0] op_a, op_b, op_result, simd_a, simd_b, wr_data, old;
    logic [31:0] current_status_word, saved_status_word;
    logic [4:0]  exc_mode, mode;
    logic [3:0]  wr_bytes;
    logic [1:0]  iset;
    psf_op_t     op_class;
    int          fails = 0;
    int          num_checks = 0;

    psf_status DUT (.clock(clock), .reset(reset), .op_valid(op_valid), .op_class(op_class),
        .op_set_flags(op_set_flags), .op_is_compare(op_is_compare), .op_dest_pc(op_dest_pc),
        .op_a(op_a), .op_b(op_b), .op_carry_in(op_carry_in), .op_result(op_result),
        .shifter_carry(shifter_carry), .sat_set(sat_set), .simd_valid(simd_valid),
        .simd_half(simd_half), .simd_signed(simd_signed), .simd_sub(simd_sub),
        .simd_a(simd_a), .simd_b(simd_b), .wr_valid(wr_valid), .wr_saved(wr_saved),
        .wr_bytes(wr_bytes), .wr_data(wr_data), .bx_valid(bx_valid),
        .bx_to_bytecode(bx_to_bytecode), .bx_target_lsb(bx_target_lsb),
        .accel_enable(accel_enable), .exc_valid(exc_valid), .exc_mode(exc_mode),
        .exc_big_endian(exc_big_endian), .irq_req(irq_req), .fiq_req(fiq_req),
        .abort_req(abort_req), .current_status_word(current_status_word),
        .saved_status_word(saved_status_word), .mode(mode), .iset(iset),
        .data_big_endian(data_big_endian), .irq_accept(irq_accept),
        .fiq_accept(fiq_accept), .abort_accept(abort_accept), .compact_fault(compact_fault));

    psf_exc_model EXC (.clock(clock), .exc_valid(exc_valid), .exc_mode(exc_mode),
        .exc_big_endian(exc_big_endian), .irq_req(irq_req), .fiq_req(fiq_req),
        .abort_req(abort_req));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic fin;
        @(posedge clock);
        {op_valid, simd_valid, wr_valid, bx_valid} <= 4'h0;
        #1;
    endtask

    task automatic op(psf_op_t c, logic sf, logic cmp, logic pc, logic [31:0] a, logic [31:0] b,
                      logic [31:0] r, logic sc, logic sat);
        @(posedge clock);
        op_class <= c;
        {op_set_flags, op_is_compare, op_dest_pc} <= {sf, cmp, pc};
        {op_a, op_b, op_result, shifter_carry, sat_set} <= {a, b, r, sc, sat};
        op_carry_in <= (c == PSF_OP_SUB);
        op_valid    <= 1'b1;
        fin();
    endtask

    task automatic simd(logic h, logic s, logic sb, logic [31:0] a, logic [31:0] b);
        @(posedge clock);
        {simd_half, simd_signed, simd_sub, simd_a, simd_b} <= {h, s, sb, a, b};
        simd_valid <= 1'b1;
        fin();
    endtask

    task automatic wr(logic sv, logic [3:0] be, logic [31:0] d);
        @(posedge clock);
        {wr_saved, wr_bytes, wr_data, wr_valid} <= {sv, be, d, 1'b1};
        fin();
    endtask

    task automatic bx(logic tob, logic lsb);
        @(posedge clock);
        {bx_to_bytecode, bx_target_lsb, bx_valid} <= {tob, lsb, 1'b1};
        fin();
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // a hang ends the run as a failure
    initial
    begin
        #200000;
        fails++;
        conclude();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        {op_valid, simd_valid, wr_valid, bx_valid, op_set_flags, op_is_compare} = 6'h00;
        {op_dest_pc, op_carry_in, shifter_carry, sat_set, simd_half} = 5'h00;
        {simd_signed, simd_sub, wr_saved, bx_to_bytecode, bx_target_lsb} = 5'h00;
        {op_a, op_b, op_result, simd_a, simd_b, wr_data} = '0;
        wr_bytes = 4'h0;
        op_class = PSF_OP_LOGIC;
        accel_enable = 1'b1;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        #1;
        `CHK("reset word", 32'h000001D3, current_status_word)
        `CHK("reset saved", 32'h00000000, saved_status_word)
        `CHK("irq masked", 1'b0, irq_accept)
        `CHK("fiq masked", 1'b0, fiq_accept)
        `CHK("abort masked", 1'b0, abort_accept)
        op(PSF_OP_LOGIC, 0, 0, 0, 0, 0, 0, 0, 1);
        op(PSF_OP_LOGIC, 0, 0, 0, 0, 0, 0, 0, 0);
        `CHK("sticky sat", 1'b1, current_status_word[27])
        wr(0, 4'h8, 32'h00000000);
        `CHK("sat cleared", 1'b0, current_status_word[27])
        op(PSF_OP_ADD, 1, 0, 0, 32'hFFFFFFFF, 32'h00000001, 0, 0, 0);
        `CHK("add carry", 4'h6, current_status_word[31:28])
        op(PSF_OP_ADD, 1, 0, 0, 32'h7FFFFFFF, 32'h00000001, 0, 0, 0);
        `CHK("add overflow", 4'h9, current_status_word[31:28])
        op(PSF_OP_SHIFT, 1, 0, 0, 0, 0, 32'h00000000, 0, 0);
        `CHK("shift flags", 4'h5, current_status_word[31:28])
        op(PSF_OP_LOGIC, 1, 0, 0, 0, 0, 32'h80000000, 1, 0);
        `CHK("logic flags", 4'h9, current_status_word[31:28])
        op(PSF_OP_SUB, 1, 0, 0, 32'h00000000, 32'h00000001, 0, 0, 0);
        `CHK("sub borrow", 4'h8, current_status_word[31:28])
        op(PSF_OP_SUB, 1, 0, 0, 32'h00000005, 32'h00000005, 0, 0, 0);
        `CHK("sub equal", 4'h6, current_status_word[31:28])
        op(PSF_OP_ADD, 0, 0, 0, 32'h7FFFFFFF, 32'h00000001, 0, 0, 0);
        `CHK("plain add", 4'h6, current_status_word[31:28])
        op(PSF_OP_SUB, 0, 1, 0, 32'h00000001, 32'h00000002, 0, 0, 0);
        `CHK("compare", 4'h8, current_status_word[31:28])
        wr(1, 4'hF, 32'h28000093);
        `CHK("saved write", 32'h28000093, saved_status_word)
        op(PSF_OP_ADD, 1, 0, 1, 32'h00000001, 32'h00000001, 0, 0, 0);
        `CHK("return copy", 32'h28000093, current_status_word)
        simd(0, 0, 0, 32'h8001FF00, 32'h80010100);
        `CHK("byte add lanes", 4'hA, current_status_word[19:16])
        simd(1, 0, 0, 32'hFFFF0001, 32'h00010001);
        `CHK("half add lanes", 4'hC, current_status_word[19:16])
        simd(0, 1, 1, 32'h01008005, 32'h02000103);
        `CHK("byte signed sub", 4'h5, current_status_word[19:16])
        simd(1, 0, 1, 32'h00010005, 32'h00020003);
        `CHK("half unsigned sub", 4'h3, current_status_word[19:16])
        wr(0, 4'h3, 32'h00000013);
        @(posedge clock);
        #1;
        `CHK("irq open", 1'b1, irq_accept)
        `CHK("fiq open", 1'b1, fiq_accept)
        `CHK("abort open", 1'b1, abort_accept)
        wr(0, 4'h2, 32'h00000200);
        `CHK("big endian", 1'b1, data_big_endian)
        old = current_status_word;
        EXC.enter(MODE_IRQ, 1'b0);
        `CHK("irq mode", MODE_IRQ, mode)
        `CHK("irq saved", old, saved_status_word)
        `CHK("entry endian", 1'b0, data_big_endian)
        @(posedge clock);
        #1;
        `CHK("irq blocked", 1'b0, irq_accept)
        EXC.enter(MODE_FIQ, 1'b0);
        @(posedge clock);
        #1;
        `CHK("fiq mode", MODE_FIQ, mode)
        `CHK("fiq blocked", 1'b0, fiq_accept)
        EXC.enter(MODE_SVC, 1'b0);
        wr(0, 4'hF, 32'hFFFFFFFF);
        `CHK("reserved ignored", 32'hF80F03FF, current_status_word)
        `CHK("system mode", MODE_SYS, mode)
        `CHK("system saved", 32'h00000000, saved_status_word)
        `CHK("compact set", 2'b01, iset)
        `CHK("no fault", 1'b0, compact_fault)
        `CHK("abort blocked", 1'b0, abort_accept)
        bx(0, 0);
        `CHK("base set", 2'b00, iset)
        bx(1, 1);
        `CHK("bytecode as exchange", 2'b01, iset)
        bx(1, 0);
        `CHK("bytecode bit clear", 2'b00, iset)
        wr(0, 4'h1, 32'h00000010);
        `CHK("user mode", MODE_USR, mode)
        wr(0, 4'hF, 32'h00000000);
        `CHK("user write", 32'h00000110, current_status_word)
        EXC.enter(MODE_UND, 1'b0);
        `CHK("und mode", MODE_UND, mode)
        `CHK("und saved", 32'h00000110, saved_status_word)
        conclude();
    end
endmodule // program_status_flags_tb
